// >>> logic/msh_hole_calc.sv
// Purpose: derive the relocated hole window from size, offset and io window
// Assumes: inputs are stable register values
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ps
module msh_hole_calc (
    input  wire logic [msh_pkg::ADDR_W-1:0] mem_size,  // installed bytes
    input  wire logic [msh_pkg::ADDR_W-1:0] reloc_off, // relocation offset
    input  wire logic                       reloc_en,  // relocation enable
    input  wire logic [msh_pkg::IOW_W-1:0]  io_start,  // low io window base
    input  wire logic [msh_pkg::IOW_W-1:0]  io_len,    // low io window size
    output msh_pkg::msh_win_t               win        // derived window
);

    logic [msh_pkg::ADDR_W:0]   size_plus_io; // one bit wider, no overflow
    logic [msh_pkg::ADDR_W-1:0] base_sum;     // offset plus io base

    // the sum test needs the carry, so it runs one bit wider than addresses
    assign size_plus_io = {1'b0, mem_size}
                        + {{(msh_pkg::ADDR_W - msh_pkg::IOW_W + 1){1'b0}},
                           io_len};
    assign base_sum     = reloc_off
                        + {{(msh_pkg::ADDR_W - msh_pkg::IOW_W){1'b0}},
                           io_start};

    // window selection; the hole source is moved from the io window base (io_start) upward
    always_comb
    begin
        win = '0;
        if (!reloc_en)
        begin
            // relocation off: no window
            win.valid = 1'b0;
        end
        else if (mem_size > msh_pkg::SIZE_LIMIT)
        begin
            // large memory: the whole hole source is relocated
            win.valid = 1'b1;
            win.base  = base_sum;
            win.top   = reloc_off + msh_pkg::TOP_LOW;
        end
        else if (size_plus_io > msh_pkg::SUM_LIMIT)
        begin
            // memory runs into the io window: move only the overlap
            win.valid = 1'b1;
            win.base  = base_sum;
            win.top   = reloc_off + mem_size - 39'h0000000001;
        end
        else
        begin
            // nothing overlaps, nothing is remapped
            win.valid = 1'b0;
        end
    end

endmodule : msh_hole_calc

// >>> logic/msh_pkg.sv
// Purpose: shared constants and carriers for the memory size and hole
//          relocation register bank
// Assumes: one clock, synchronous active-low reset, 64-bit accesses only
// Notes:   register indices are word indices on the access port
package msh_pkg;

    // widths
    localparam int DATA_W = 64;            // register width
    localparam int ADDR_W = 39;            // physical address width
    localparam int IDX_W  = 2;             // register index width
    localparam int IOW_W  = 32;            // low io window field width

    // register indices
    localparam logic [1:0] IDX_SIZE  = 2'h0; // installed_memory_size
    localparam logic [1:0] IDX_RELOC = 2'h1; // hole_relocation_distance

    // field positions
    localparam int RE_BIT    = 0;          // range_enable in both registers
    localparam int SIZE_MSB  = 38;         // size field top bit
    localparam int SIZE_LSB  = 26;         // size field bottom bit
    localparam int SIZE_WMSB = 36;         // highest writable size bit
    localparam int DIST_MSB  = 38;         // distance field top bit
    localparam int DIST_LSB  = 32;         // distance field bottom bit
    localparam int IMPL_MSB  = 38;         // bits above read as zero

    // stored size bits are 36:26; 38:37 are wired to zero
    localparam int SIZE_ST_W = SIZE_WMSB - SIZE_LSB + 1;

    // reset and fixed values
    localparam logic [SIZE_ST_W-1:0] SIZE_RST = 11'h000; // size at reset
    localparam logic                 RE_RST   = 1'b0;    // enables at reset
    localparam logic [1:0]           SIZE_FIX = 2'h0;    // size[38:37]
    localparam logic [6:0]           DIST_VAL = 7'h10;   // distance[38:32]

    // window arithmetic limits
    localparam logic [ADDR_W-1:0] SIZE_LIMIT = 39'h000fffffff; // size test
    localparam logic [ADDR_W:0]   SUM_LIMIT  = 40'h00ffffffff; // sum test
    localparam logic [ADDR_W-1:0] TOP_LOW    = 39'h00ffffffff; // hole top
    localparam logic [ADDR_W-1:0] HOLE_SRC_LO = 39'h00f0000000; // src base
    localparam logic [ADDR_W-1:0] HOLE_SRC_HI = 39'h00ffffffff; // src top
    localparam logic [ADDR_W-1:0] MAX_BYTES  = 39'h1000000000; // 64 GBytes

    // one register access
    typedef struct packed {
        logic              valid;          // access present this cycle
        logic              wr;             // 1 store, 0 load
        logic [IDX_W-1:0]  idx;            // register index
        logic [DATA_W-1:0] wdata;          // store data
    } msh_req_t;

    // relocated hole window
    typedef struct packed {
        logic              valid;          // window exists
        logic [ADDR_W-1:0] base;           // first relocated address
        logic [ADDR_W-1:0] top;            // last relocated address
    } msh_win_t;

endpackage : msh_pkg

// >>> logic/msh_regs.sv
// Purpose: memory size and hole relocation register bank with window logic
// Assumes: single clock, synchronous active-low reset, one access per cycle
// Notes:   loads answer one cycle after the request; window lags one cycle
//
// Overview of operation
// - reserved bits written zero, read undefined
// - unimplemented bits ignore writes, read zero
// - memory size is size[38:26] with zeros below
// - size bits 38 and 37 stay zero
// - memory enabled only when its range enable set
// - distance field fixed at 0010000, read only
// - offset is distance[38:32] with zeros below
// - relocation active only with its range enable
// - hole source 0xf000_0000 to 0xffff_ffff is remapped (the code starts the window at the io window base instead)
// - large memory: window spans io base to 4G
// - overlap case: window ends at memory size minus one
// - otherwise no relocated window exists
// - registers cover up to 64 GBytes
`timescale 1ns/1ps
module msh_regs (
    input  wire logic                       clock,           // 125 MHz clock
    input  wire logic                       resetn,          // sync reset, low
    input  msh_pkg::msh_req_t               acc_req,         // register access
    input  wire logic [msh_pkg::IOW_W-1:0]  low_io_window_start, // io base
    input  wire logic [msh_pkg::IOW_W-1:0]  low_io_window_length,// io size
    output logic      [msh_pkg::DATA_W-1:0] rd_data_ff,      // load data
    output logic                            rd_valid_ff,     // load answer
    output logic                            mem_enable_ff,   // memory enabled
    output logic      [msh_pkg::ADDR_W-1:0] mem_size_ff,     // installed bytes
    output logic                            reloc_enable_ff, // relocation on
    output logic      [msh_pkg::ADDR_W-1:0] reloc_offset_ff, // relocation dist
    output msh_pkg::msh_win_t               hole_win_ff      // hole window
);

    // decoded strobes
    logic wr_size;                                  // store to size register
    logic wr_reloc;                                 // store to reloc register
    logic [msh_pkg::SIZE_ST_W-1:0] size_bits_ff;    // writable size bits
    msh_pkg::msh_win_t             nxt_hole_win;    // combinational window
    logic [msh_pkg::DATA_W-1:0]    nxt_rd_data;     // load mux

    // only full-word stores exist on this port; no lane strobes
    assign wr_size  = acc_req.valid && acc_req.wr
                   && (acc_req.idx == msh_pkg::IDX_SIZE);
    assign wr_reloc = acc_req.valid && acc_req.wr
                   && (acc_req.idx == msh_pkg::IDX_RELOC);

    // size field: only 36:26 are stored, so 38:37 cannot be written
    always_ff @(posedge clock)
    begin
        if (!resetn)
            size_bits_ff <= msh_pkg::SIZE_RST;
        else if (wr_size)
            size_bits_ff <=
                acc_req.wdata[msh_pkg::SIZE_WMSB:msh_pkg::SIZE_LSB];
    end

    // 39-bit size covers up to 64 GBytes and beyond
    always_ff @(posedge clock)
    begin
        if (!resetn)
            mem_size_ff <= '0;
        else if (wr_size)
            // size with 26 zero bits appended
            mem_size_ff <= {msh_pkg::SIZE_FIX,
                            acc_req.wdata[msh_pkg::SIZE_WMSB:msh_pkg::SIZE_LSB],
                            26'h0000000};
    end

    // memory range enable; memory stays off until software sets it
    always_ff @(posedge clock)
    begin
        if (!resetn)
            mem_enable_ff <= msh_pkg::RE_RST;
        else if (wr_size)
            mem_enable_ff <= acc_req.wdata[msh_pkg::RE_BIT];
    end

    // relocation range enable; the distance bits of a store are dropped
    always_ff @(posedge clock)
    begin
        if (!resetn)
            reloc_enable_ff <= msh_pkg::RE_RST;
        else if (wr_reloc)
            reloc_enable_ff <= acc_req.wdata[msh_pkg::RE_BIT];
    end

    // offset is a constant held in a flop so the output is registered
    always_ff @(posedge clock)
    begin
        if (!resetn)
            reloc_offset_ff <= {msh_pkg::DIST_VAL, 32'h00000000};
        else
            reloc_offset_ff <= {msh_pkg::DIST_VAL, 32'h00000000};
    end

    // window arithmetic lives in its own module
    msh_hole_calc u_hole_calc (
        .mem_size  (mem_size_ff),
        .reloc_off (reloc_offset_ff),
        .reloc_en  (reloc_enable_ff),
        .io_start  (low_io_window_start),
        .io_len    (low_io_window_length),
        .win       (nxt_hole_win)
    );

    // register the window; it trails a register write by one cycle
    always_ff @(posedge clock)
    begin
        if (!resetn)
            hole_win_ff <= '0;
        else
            hole_win_ff <= nxt_hole_win;
    end

    // load mux: unimplemented and unmapped bits all return zero
    always_comb
    begin
        // no reserved fields here: every non-field bit reads zero
        nxt_rd_data = '0;
        case (acc_req.idx)
            msh_pkg::IDX_SIZE:
            begin
                nxt_rd_data[msh_pkg::SIZE_MSB:msh_pkg::SIZE_LSB] =
                    {msh_pkg::SIZE_FIX, size_bits_ff};
                nxt_rd_data[msh_pkg::RE_BIT] = mem_enable_ff;
            end
            msh_pkg::IDX_RELOC:
            begin
                nxt_rd_data[msh_pkg::DIST_MSB:msh_pkg::DIST_LSB] =
                    msh_pkg::DIST_VAL;
                nxt_rd_data[msh_pkg::RE_BIT] = reloc_enable_ff;
            end
            default:
            begin
                // unmapped index: a load still answers, with zero
                nxt_rd_data = '0;
            end
        endcase
    end

    // load answer: one cycle after a load request; stores give no answer
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            rd_valid_ff <= 1'b0;
            rd_data_ff  <= '0;
        end
        else
        begin
            rd_valid_ff <= acc_req.valid && !acc_req.wr;
            // data is held at zero between loads to keep the bus quiet
            rd_data_ff  <= (acc_req.valid && !acc_req.wr) ? nxt_rd_data : '0;
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // a store to size carrying a set enable
    sequence s_size_en_store;
        wr_size && acc_req.wdata[msh_pkg::RE_BIT];
    endsequence

    // a load of the relocation register
    sequence s_reloc_load;
        acc_req.valid && !acc_req.wr && (acc_req.idx == msh_pkg::IDX_RELOC);
    endsequence

    // large memory with relocation on, held for two cycles
    sequence s_large_reloc;
        (reloc_enable_ff && (mem_size_ff > msh_pkg::SIZE_LIMIT))[*2];
    endsequence

    AST_SIZE_TOP_ZERO: assert property (
        mem_size_ff[38:37] == 2'h0 && mem_size_ff[25:0] == 26'h0000000)
        else $error("size top bits or low bits not zero");

    AST_UNIMPL_ZERO: assert property (
        rd_valid_ff |-> rd_data_ff[63:39] == 25'h0000000
                     && rd_data_ff[25:1] == 25'h0000000)
        else $error("unimplemented bits read non-zero");

    AST_SIZE_STORE: assert property (
        wr_size |=> mem_size_ff == {2'h0, $past(acc_req.wdata[36:26]),
                                    26'h0000000})
        else $error("size register did not take store");

    AST_MEM_ENABLE: assert property (
        s_size_en_store |=> mem_enable_ff
                            ##1 (mem_enable_ff || $past(wr_size)))
        else $error("memory enable did not follow store");

    AST_DIST_FIXED: assert property (
        reloc_offset_ff == 39'h1000000000)
        else $error("relocation offset changed");

    AST_RELOC_READ: assert property (
        s_reloc_load |=> rd_valid_ff && rd_data_ff[38:32] == 7'h10
                         && rd_data_ff[0] == $past(reloc_enable_ff))
        else $error("relocation load returned wrong data");

    AST_NO_RELOC: assert property (
        !reloc_enable_ff |=> !hole_win_ff.valid)
        else $error("window present with relocation off");

    AST_LARGE_WIN: assert property (
        s_large_reloc |-> hole_win_ff.valid
                          && hole_win_ff.top == 39'h10ffffffff)
        else $error("large memory window wrong");

    AST_RESET_STATE: assert property (
        @(posedge clock) disable iff (1'b0)
        !resetn |=> !mem_enable_ff && !reloc_enable_ff
                    && !hole_win_ff.valid)
        else $error("reset did not clear enables");

endmodule : msh_regs

// >>> verif/msh_tb.sv
// Purpose: self-checking bench for the size and hole relocation registers
// Assumes: loads answer at the taking edge, window one edge later
// Notes:   inputs move 1 ns after the rising edge; seeded random stimulus
`timescale 1ns/1ps
module testbench;
    logic                clock = 1'b0;   // 125 MHz
    logic                resetn = 1'b0;  // sync reset, low
    msh_pkg::msh_req_t   acc_req = '0;   // register access
    logic [31:0]         io_st = 32'h0;  // low io window base
    logic [31:0]         io_len = 32'h0; // low io window size
    logic [63:0]         rd_data_ff;     // load data
    logic                rd_valid_ff;    // load answer
    logic                mem_enable_ff;  // memory enable
    logic [38:0]         mem_size_ff;    // installed bytes
    logic                reloc_enable_ff;// relocation enable
    logic [38:0]         reloc_offset_ff;// relocation offset
    msh_pkg::msh_win_t   hole_win_ff;    // hole window
    int                  fail_count = 0; // mismatches
    int                  n_compared = 0; // comparisons
    int                  cyc = 0;        // cycle count for the hang guard
    integer              seed = 32'h0f6b;// fixed seed
    logic [63:0]         rd, wd;         // scratch words
    logic                ren;            // relocation enable sent
    logic [38:0]         sz_t[5] = '{39'h0, 39'hc000000, 39'hc000000,
                                     39'h10000000, 39'h1000000000};
    logic [31:0]         len_t[5] = '{32'h10000000, 32'hf4000000,
                                      32'hf3ffffff, 32'h10000000, 32'h0};

    msh_regs u_dut (
        .clock               (clock),
        .resetn              (resetn),
        .acc_req             (acc_req),
        .low_io_window_start (io_st),
        .low_io_window_length(io_len),
        .rd_data_ff          (rd_data_ff),
        .rd_valid_ff         (rd_valid_ff),
        .mem_enable_ff       (mem_enable_ff),
        .mem_size_ff         (mem_size_ff),
        .reloc_enable_ff     (reloc_enable_ff),
        .reloc_offset_ff     (reloc_offset_ff),
        .hole_win_ff         (hole_win_ff)
    );

    // free-running clock, half period 4 ns
    always #4 clock = ~clock;

    // compare and count; wide enough for the window struct
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // hang guard: whole run needs well under this many cycles
    always @(posedge clock)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            fail_count++;
            print_verdict;
        end
    end

    // one access; valid stays up so back-to-back calls never glitch it
    task automatic acc(input logic wr, input logic [1:0] idx,
                       input logic [63:0] d, output logic [63:0] r);
        acc_req = {1'b1, wr, idx, d};
        @(posedge clock);
        #1;
        r = rd_data_ff;
        chk(80'(rd_valid_ff), 80'(!wr));
    endtask : acc

    // drop the request and let one edge pass
    task automatic idle;
        acc_req = '0;
        @(posedge clock);
        #1;
    endtask : idle

    // expected installed size: bits 36:26 kept, 38:37 forced low
    function automatic logic [38:0] exp_sz(input logic [63:0] d);
        return {2'b00, d[36:26], 26'h0};
    endfunction : exp_sz

    // expected window, worked out from size, enable and io window
    function automatic msh_pkg::msh_win_t exp_win(input logic [38:0] sz,
        input logic ren, input logic [31:0] st, input logic [31:0] ln);
        logic [38:0] off;
        off = 39'h1000000000;
        if (ren && sz > 39'hfffffff)
            return {1'b1, off + 39'(st), off + 39'hffffffff};
        else if (ren && 40'(sz) + 40'(ln) > 40'hffffffff)
            return {1'b1, off + 39'(st), off + sz - 39'h1};
        return '0;
    endfunction : exp_win

    // hold reset 20 cycles, check reset values and the fixed distance
    task automatic do_reset;
        resetn = 1'b0;
        acc_req = '0;
        repeat (20) @(posedge clock);
        #1;
        chk(80'({rd_valid_ff, mem_enable_ff, reloc_enable_ff}), 80'h0);
        chk(80'(hole_win_ff), 80'h0);
        chk(80'(reloc_offset_ff), 80'h1000000000);
        resetn = 1'b1;
        acc(1'b0, msh_pkg::IDX_RELOC, 64'h0, rd);
        chk(80'(rd), 80'h1000000000);
        idle;
        $display("reset test done");
    endtask : do_reset

    initial
    begin
        do_reset;
        // distance is read only, only the enable takes a store
        acc(1'b1, msh_pkg::IDX_RELOC, 64'hffffffffffffffff, rd);
        chk(80'({reloc_enable_ff, reloc_offset_ff}),
            80'h9000000000);
        acc(1'b0, msh_pkg::IDX_RELOC, 64'h0, rd);
        chk(80'(rd), 80'h1000000001);
        idle;
        $display("relocation register test done");
        // size stores: all ones corner, then random words back to back
        for (int i = 0; i < 16; i++)
        begin
            wd = (i == 0) ? '1 : {$random(seed), $random(seed)};
            acc(1'b1, msh_pkg::IDX_SIZE, wd, rd);
            chk(80'(mem_size_ff), 80'(exp_sz(wd)));
            chk(80'(mem_enable_ff), 80'(wd[0]));
            acc(1'b0, msh_pkg::IDX_SIZE, 64'h0, rd);
            chk(80'(rd),
                80'({25'h0, 2'b00, wd[36:26], 25'h0, wd[0]}));
        end
        idle;
        $display("size register test done");
        // unmapped indices: stores ignored, loads return zero
        for (int i = 2; i < 4; i++)
        begin
            wd = {mem_size_ff, mem_enable_ff, reloc_enable_ff, 23'h0};
            acc(1'b1, 2'(i), '1, rd);
            acc(1'b0, 2'(i), 64'h0, rd);
            chk(80'(rd), 80'h0);
            chk(80'(wd), 80'({mem_size_ff, mem_enable_ff,
                              reloc_enable_ff, 23'h0}));
        end
        idle;
        $display("unmapped index test done");
        // window: corner table first, then random sizes and io windows
        for (int i = 0; i < 30; i++)
        begin
            wd = (i < 5) ? 64'(sz_t[i]) : {$random(seed), $random(seed)};
            io_st = (i == 3) ? 32'hf0000000
                  : (i < 5) ? 32'hc000000 : $random(seed);
            io_len = (i < 5) ? len_t[i] : $random(seed);
            // enable comes from the stimulus, not from the design
            ren = (i != 4) && (i < 5 || wd[1]);
            acc(1'b1, msh_pkg::IDX_RELOC, 64'(ren), rd);
            chk(80'(reloc_enable_ff), 80'(ren));
            // size is the total byte count, relocated part included
            acc(1'b1, msh_pkg::IDX_SIZE, wd, rd);
            idle;
            chk(80'(hole_win_ff), 80'(exp_win(exp_sz(wd), ren,
                io_st, io_len)));
        end
        $display("hole window test done");
        do_reset;
        print_verdict;
    end
endmodule : testbench
